// ---- csbu_defs.vh ----
`ifndef CSBU_DEFS_VH
`define CSBU_DEFS_VH
// status register bit positions
`define CSBU_FLAG_C 3'd0
`define CSBU_FLAG_Z 3'd1
`define CSBU_FLAG_N 3'd2
`define CSBU_FLAG_V 3'd3
`define CSBU_FLAG_S 3'd4
`define CSBU_FLAG_H 3'd5
`define CSBU_FLAG_T 3'd6
`define CSBU_FLAG_I 3'd7
// operation codes on i_op
`define CSBU_OP_NONE      5'h00
`define CSBU_OP_CMP_SKIP  5'h01
`define CSBU_OP_CMP       5'h02
`define CSBU_OP_CMP_C     5'h03
`define CSBU_OP_CMP_IMM   5'h04
`define CSBU_OP_SKIP_RBC  5'h05
`define CSBU_OP_SKIP_RBS  5'h06
`define CSBU_OP_SKIP_IOC  5'h07
`define CSBU_OP_SKIP_IOS  5'h08
`define CSBU_OP_BR_SET    5'h09
`define CSBU_OP_BR_CLR    5'h0A
`define CSBU_OP_BR_EQ     5'h0B
`define CSBU_OP_BR_NE     5'h0C
`define CSBU_OP_BR_CS     5'h0D
`define CSBU_OP_BR_CC     5'h0E
`define CSBU_OP_BR_SH     5'h0F
`define CSBU_OP_BR_LO     5'h10
`define CSBU_OP_BR_MI     5'h11
`define CSBU_OP_BR_PL     5'h12
`define CSBU_OP_BR_GE     5'h13
`define CSBU_OP_BR_LT     5'h14
`define CSBU_OP_BR_HS     5'h15
`define CSBU_OP_BR_HC     5'h16
`define CSBU_OP_BR_TS     5'h17
// reset values and cycle counts
`define CSBU_STATUS_RST   8'h00
`define CSBU_PC_RST       16'h0000
`define CSBU_CYC_BR_TAKEN 2'd2
`define CSBU_CYC_SKIP1    2'd2
`define CSBU_CYC_SKIP2    2'd3
`endif

// ---- csbu_sub_flags.v ----
`include "csbu_defs.vh"
// subtract without storing, producing status flags
module csbu_sub_flags (
	input  wire [7:0] i_a,
	input  wire [7:0] i_b,
	input  wire       i_cin,
	input  wire       i_keep_z,
	input  wire       i_z_old,
	output wire [5:0] o_flags
);
	wire [8:0] diff;
	wire [7:0] r;
	wire       fc;
	wire       fz;
	wire       fn;
	wire       fv;
	wire       fh;

	// borrow chain and flag equations
	assign diff = {1'b0, i_a} - {1'b0, i_b} - {8'h00, i_cin};
	assign r    = diff[7:0];
	assign fc   = (~i_a[7] & i_b[7]) | (i_b[7] & r[7]) | (r[7] & ~i_a[7]);
	assign fh   = (~i_a[3] & i_b[3]) | (i_b[3] & r[3]) | (r[3] & ~i_a[3]);
	assign fv   = (i_a[7] & ~i_b[7] & ~r[7]) | (~i_a[7] & i_b[7] & r[7]);
	assign fn   = r[7];
	// with-carry form keeps zero only while result stays zero
	assign fz   = (r == 8'h00) & (~i_keep_z | i_z_old);
	// order: h s v n z c
	assign o_flags = {fh, fn ^ fv, fv, fn, fz, fc};
endmodule

// ---- csbu_core.v ----
`include "csbu_defs.vh"
module csbu_core #(
	parameter PC_W = 16,
	parameter OFS_W = 7
) (
	input  wire              i_clock,
	input  wire              i_nrst,
	input  wire              i_enable,
	input  wire              i_start,
	input  wire [4:0]        i_op,
	input  wire [7:0]        i_rd,
	input  wire [7:0]        i_rr,
	input  wire [7:0]        i_imm,
	input  wire [2:0]        i_bit_sel,
	input  wire [7:0]        i_io_data,
	input  wire [OFS_W-1:0]  i_offset,
	input  wire              i_next_two_word,
	input  wire [PC_W-1:0]   i_pc,
	input  wire              i_status_wr,
	input  wire [7:0]        i_status_wdata,
	output reg  [7:0]        o_status,
	output reg  [PC_W-1:0]   o_pc_next,
	output reg               o_pc_load,
	output reg               o_busy,
	output reg               o_done,
	output reg               o_flags_upd
);
	localparam ST_IDLE = 1'b0;
	localparam ST_WAIT = 1'b1;

	// sequencer state and next-state values
	reg        state_q;
	reg        state_d;
	reg  [1:0] wait_q;
	reg  [1:0] wait_d;
	reg  [7:0] status_d;
	reg  [PC_W-1:0] pc_next_d;
	reg        pc_load_d;
	reg        done_d;
	reg        upd_d;
	reg        cond;
	reg        is_skip;
	reg        is_br;
	reg        is_cmp;
	reg  [7:0] cmp_b;
	reg        cmp_cin;
	reg        keep_z;
	wire [5:0] flags;
	wire [PC_W-1:0] ofs_ext;
	wire [PC_W-1:0] br_target;
	wire [PC_W-1:0] skip_target;
	wire [PC_W-1:0] skip_ofs;
	wire [1:0]      skip_cyc;
	// bit-select and flag helpers
	wire [7:0]      bit_hot;
	wire [7:0]      rr_hit;
	wire [7:0]      io_hit;
	wire [7:0]      st_hit;
	wire            rr_bit;
	wire            io_bit;
	wire            st_bit;
	wire            flag_c;
	wire            flag_z;
	wire            flag_n;
	wire            flag_v;
	wire            flag_h;
	wire            flag_t;
	wire            signed_lt;

	// sign extended displacement and targets
	assign ofs_ext     = {{(PC_W-OFS_W){i_offset[OFS_W-1]}}, i_offset};
	assign br_target   = i_pc + ofs_ext + {{(PC_W-1){1'b0}}, 1'b1};
	assign skip_ofs    = {{(PC_W-2){1'b0}}, (i_next_two_word ? 2'd3 : 2'd2)};
	assign skip_target = i_pc + skip_ofs;
	assign skip_cyc    = i_next_two_word ? `CSBU_CYC_SKIP2 : `CSBU_CYC_SKIP1;

	// named status flags feeding the branch conditions
	assign flag_c    = o_status[`CSBU_FLAG_C];
	assign flag_z    = o_status[`CSBU_FLAG_Z];
	assign flag_n    = o_status[`CSBU_FLAG_N];
	assign flag_v    = o_status[`CSBU_FLAG_V];
	assign flag_h    = o_status[`CSBU_FLAG_H];
	assign flag_t    = o_status[`CSBU_FLAG_T];
	assign signed_lt = flag_n ^ flag_v;

	// one-hot bit index, one slice per bit position
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_bit
			assign bit_hot[gi] = ({29'd0, i_bit_sel} == gi);
			assign rr_hit[gi]  = bit_hot[gi] & i_rr[gi];
			assign io_hit[gi]  = bit_hot[gi] & i_io_data[gi];
			assign st_hit[gi]  = bit_hot[gi] & o_status[gi];
		end
	endgenerate
	assign rr_bit = |rr_hit;
	assign io_bit = |io_hit;
	assign st_bit = |st_hit;

	// operand selection for the compare forms
	always @* begin
		is_cmp  = 1'b0;
		cmp_b   = i_rr;
		cmp_cin = 1'b0;
		keep_z  = 1'b0;
		case (i_op)
			`CSBU_OP_CMP: begin
				is_cmp = 1'b1;
			end
			`CSBU_OP_CMP_C: begin
				is_cmp  = 1'b1;
				cmp_cin = o_status[`CSBU_FLAG_C];
				keep_z  = 1'b1;
			end
			`CSBU_OP_CMP_IMM: begin
				is_cmp = 1'b1;
				cmp_b  = i_imm;
			end
			default: begin
				is_cmp = 1'b0;
			end
		endcase
	end

	csbu_sub_flags u_sub (
		.i_a      (i_rd),
		.i_b      (cmp_b),
		.i_cin    (cmp_cin),
		.i_keep_z (keep_z),
		.i_z_old  (o_status[`CSBU_FLAG_Z]),
		.o_flags  (flags)
	);

	// condition evaluation per operation
	always @* begin
		cond    = 1'b0;
		is_skip = 1'b0;
		is_br   = 1'b0;
		case (i_op)
			`CSBU_OP_CMP_SKIP: begin
				is_skip = 1'b1;
				cond    = (i_rd == i_rr);
			end
			`CSBU_OP_SKIP_RBC: begin
				is_skip = 1'b1;
				cond    = ~rr_bit;
			end
			`CSBU_OP_SKIP_RBS: begin
				is_skip = 1'b1;
				cond    = rr_bit;
			end
			`CSBU_OP_SKIP_IOC: begin
				is_skip = 1'b1;
				cond    = ~io_bit;
			end
			`CSBU_OP_SKIP_IOS: begin
				is_skip = 1'b1;
				cond    = io_bit;
			end
			`CSBU_OP_BR_SET: begin
				is_br = 1'b1;
				cond  = st_bit;
			end
			`CSBU_OP_BR_CLR: begin
				is_br = 1'b1;
				cond  = ~st_bit;
			end
			`CSBU_OP_BR_EQ: begin
				is_br = 1'b1;
				cond  = flag_z;
			end
			`CSBU_OP_BR_NE: begin
				is_br = 1'b1;
				cond  = ~flag_z;
			end
			`CSBU_OP_BR_CS, `CSBU_OP_BR_LO: begin
				is_br = 1'b1;
				cond  = flag_c;
			end
			`CSBU_OP_BR_CC, `CSBU_OP_BR_SH: begin
				is_br = 1'b1;
				cond  = ~flag_c;
			end
			`CSBU_OP_BR_MI: begin
				is_br = 1'b1;
				cond  = flag_n;
			end
			`CSBU_OP_BR_PL: begin
				is_br = 1'b1;
				cond  = ~flag_n;
			end
			`CSBU_OP_BR_GE: begin
				is_br = 1'b1;
				cond  = ~signed_lt;
			end
			`CSBU_OP_BR_LT: begin
				is_br = 1'b1;
				cond  = signed_lt;
			end
			`CSBU_OP_BR_HS: begin
				is_br = 1'b1;
				cond  = flag_h;
			end
			`CSBU_OP_BR_HC: begin
				is_br = 1'b1;
				cond  = ~flag_h;
			end
			`CSBU_OP_BR_TS: begin
				is_br = 1'b1;
				cond  = flag_t;
			end
			default: begin
				cond = 1'b0;
			end
		endcase
	end

	// sequencing: one cycle, or hold busy for the taken extra cycles
	always @* begin
		state_d   = state_q;
		wait_d    = wait_q;
		status_d  = o_status;
		pc_next_d = o_pc_next;
		pc_load_d = 1'b0;
		done_d    = 1'b0;
		upd_d     = 1'b0;
		if (i_status_wr) begin
			status_d = i_status_wdata;
		end
		case (state_q)
			ST_IDLE: begin
				if (i_start) begin
					if (is_cmp) begin
						status_d = {o_status[7:6], flags};
						upd_d    = 1'b1;
						done_d   = 1'b1;
					end else if (is_br & cond) begin
						pc_next_d = br_target;
						state_d   = ST_WAIT;
						wait_d    = `CSBU_CYC_BR_TAKEN - 2'd1;
					end else if (is_skip & cond) begin
						pc_next_d = skip_target;
						state_d   = ST_WAIT;
						wait_d    = skip_cyc - 2'd1;
					end else begin
						done_d = 1'b1;
					end
				end
			end
			ST_WAIT: begin
				wait_d = wait_q - 2'd1;
				if (wait_q == 2'd1) begin
					pc_load_d = 1'b1;
					done_d    = 1'b1;
					state_d   = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// registers, frozen while enable is low
	always @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			state_q     <= ST_IDLE;
			wait_q      <= 2'd0;
			o_status    <= `CSBU_STATUS_RST;
			o_pc_next   <= `CSBU_PC_RST;
			o_pc_load   <= 1'b0;
			o_busy      <= 1'b0;
			o_done      <= 1'b0;
			o_flags_upd <= 1'b0;
		end else if (i_enable) begin
			state_q     <= state_d;
			wait_q      <= wait_d;
			o_status    <= status_d;
			o_pc_next   <= pc_next_d;
			o_pc_load   <= pc_load_d;
			o_busy      <= (state_d == ST_WAIT);
			o_done      <= done_d;
			o_flags_upd <= upd_d;
		end
	end
endmodule

// ---- csbu_checker.sv ----
`include "csbu_defs.vh"
// timing and flag relations at the core ports
module csbu_checker #(parameter PC_W = 16, OFS_W = 7) (
	input wire logic             i_clock,
	input wire logic             i_nrst,
	input wire logic             i_enable,
	input wire logic             i_start,
	input wire logic [4:0]       i_op,
	input wire logic [7:0]       i_rd,
	input wire logic [7:0]       i_rr,
	input wire logic [2:0]       i_bit_sel,
	input wire logic [OFS_W-1:0] i_offset,
	input wire logic             i_next_two_word,
	input wire logic [PC_W-1:0]  i_pc,
	input wire logic [7:0]       o_status,
	input wire logic [PC_W-1:0]  o_pc_next,
	input wire logic             o_pc_load,
	input wire logic             o_busy,
	input wire logic             o_done,
	input wire logic             o_flags_upd
);
	wire            go = i_start & ~o_busy & i_enable;
	wire [PC_W-1:0] tgt = i_pc + PC_W'($signed(i_offset)) + 1'b1;
	wire [PC_W-1:0] nx2 = i_pc + 2'd2;
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_nrst);
	load_done_a: assert property (o_pc_load |-> o_done) else $error("pc load without done");
	upd_done_a: assert property (o_flags_upd |-> o_done) else $error("flag update without done");
	sign_flag_a: assert property (o_flags_upd |-> o_status[4] == (o_status[2] ^ o_status[3]))
		else $error("sign flag wrong");
	eq_taken_a: assert property (go && i_op == `CSBU_OP_BR_EQ && o_status[1] |=>
		o_busy ##1 o_pc_load && o_pc_next == $past(tgt, 2)) else $error("equal branch target wrong");
	ne_untaken_a: assert property (go && i_op == `CSBU_OP_BR_NE && o_status[1] |=>
		o_done && !o_pc_load) else $error("not equal branch taken");
	cmp_equal_a: assert property (go && i_op == `CSBU_OP_CMP && i_rd == i_rr |=>
		o_flags_upd && o_status[1] && !o_status[0]) else $error("equal compare flags wrong");
	skip_neq_a: assert property (go && i_op == `CSBU_OP_CMP_SKIP && i_rd != i_rr |=>
		o_done && !o_busy) else $error("unequal compare skipped");
	bit_skip_a: assert property (go && i_op == `CSBU_OP_SKIP_RBS && i_rr[i_bit_sel] && !i_next_two_word
		|=> o_busy ##1 o_pc_load && o_pc_next == $past(nx2, 2)) else $error("bit skip wrong");
endmodule

bind csbu_core csbu_checker #(.PC_W(PC_W), .OFS_W(OFS_W)) u_chk (
	.i_clock         (i_clock),
	.i_nrst          (i_nrst),
	.i_enable        (i_enable),
	.i_start         (i_start),
	.i_op            (i_op),
	.i_rd            (i_rd),
	.i_rr            (i_rr),
	.i_bit_sel       (i_bit_sel),
	.i_offset        (i_offset),
	.i_next_two_word (i_next_two_word),
	.i_pc            (i_pc),
	.o_status        (o_status),
	.o_pc_next       (o_pc_next),
	.o_pc_load       (o_pc_load),
	.o_busy          (o_busy),
	.o_done          (o_done),
	.o_flags_upd     (o_flags_upd)
);

// ---- tb.sv ----
`include "csbu_defs.vh"
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic        i_clock = 0, i_nrst = 0, i_enable = 1, i_start = 0, i_next_two_word = 0, i_status_wr = 0;
	logic [4:0]  i_op = 0, h;
	logic [7:0]  i_rd = 0, i_rr = 0, i_imm = 0, i_io_data = 0, i_status_wdata = 0, sr = 0, b;
	logic [2:0]  i_bit_sel = 0;
	logic [6:0]  i_offset = 0;
	logic [15:0] i_pc = 0, ep;
	logic [8:0]  r;
	logic        t, c, v;
	wire  [7:0]  o_status;
	wire  [15:0] o_pc_next;
	wire         o_pc_load, o_busy, o_done, o_flags_upd;
	int          n_fail = 0, n_compared = 0, cyc = 0, n;
	csbu_core DUT (
		.i_clock         (i_clock),
		.i_nrst          (i_nrst),
		.i_enable        (i_enable),
		.i_start         (i_start),
		.i_op            (i_op),
		.i_rd            (i_rd),
		.i_rr            (i_rr),
		.i_imm           (i_imm),
		.i_bit_sel       (i_bit_sel),
		.i_io_data       (i_io_data),
		.i_offset        (i_offset),
		.i_next_two_word (i_next_two_word),
		.i_pc            (i_pc),
		.i_status_wr     (i_status_wr),
		.i_status_wdata  (i_status_wdata),
		.o_status        (o_status),
		.o_pc_next       (o_pc_next),
		.o_pc_load       (o_pc_load),
		.o_busy          (o_busy),
		.o_done          (o_done),
		.o_flags_upd     (o_flags_upd)
	);
	// clock and hang guard
	always #12.5 i_clock = ~i_clock;
	always @(posedge i_clock) if (++cyc > 4000) begin
		n_fail++;
		print_verdict();
	end
	task chk(input logic [15:0] g, e);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %0t seen %h exp %h", $time, g, e);
		end
	endtask
	task print_verdict();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// one instruction: random operands, optional status write, model, compare
	task run(input logic [4:0] op, input logic eq, w);
		@(posedge i_clock);
		{i_rd, i_rr, i_imm, i_io_data, i_bit_sel, i_offset, i_pc, i_next_two_word} <= 59'({$urandom, $urandom});
		i_status_wr <= w;
		i_status_wdata <= 8'($urandom);
		@(posedge i_clock);
		i_status_wr <= 0;
		if (w) sr = i_status_wdata;
		if (eq) i_rr <= i_rd;
		i_op <= op;
		i_start <= 1;
		@(posedge i_clock);
		i_start <= 0;
		@(negedge i_clock);
		b = (op == `CSBU_OP_CMP_IMM) ? i_imm : i_rr;
		c = (op == `CSBU_OP_CMP_C) & sr[0];
		r = {1'b0, i_rd} - b - c;
		h = {1'b0, i_rd[3:0]} - b[3:0] - c;
		v = (i_rd[7] & ~b[7] & ~r[7]) | (~i_rd[7] & b[7] & r[7]);
		case (op)
			`CSBU_OP_CMP_SKIP: t = i_rd == i_rr;
			`CSBU_OP_SKIP_RBC: t = !i_rr[i_bit_sel];
			`CSBU_OP_SKIP_RBS: t = i_rr[i_bit_sel];
			`CSBU_OP_SKIP_IOC: t = !i_io_data[i_bit_sel];
			`CSBU_OP_SKIP_IOS: t = i_io_data[i_bit_sel];
			`CSBU_OP_BR_SET: t = sr[i_bit_sel];
			`CSBU_OP_BR_CLR: t = !sr[i_bit_sel];
			`CSBU_OP_BR_EQ: t = sr[1];
			`CSBU_OP_BR_NE: t = !sr[1];
			`CSBU_OP_BR_CS, `CSBU_OP_BR_LO: t = sr[0];
			`CSBU_OP_BR_CC, `CSBU_OP_BR_SH: t = !sr[0];
			`CSBU_OP_BR_MI: t = sr[2];
			`CSBU_OP_BR_PL: t = !sr[2];
			`CSBU_OP_BR_GE: t = !(sr[2] ^ sr[3]);
			`CSBU_OP_BR_LT: t = sr[2] ^ sr[3];
			`CSBU_OP_BR_HS: t = sr[5];
			`CSBU_OP_BR_HC: t = !sr[5];
			`CSBU_OP_BR_TS: t = sr[6];
			default: t = 0;
		endcase
		ep = op > 8 ? i_pc + {{9{i_offset[6]}}, i_offset} + 1 : i_pc + 2 + i_next_two_word;
		if (op inside {2, 3, 4})
			sr = {sr[7:6], h[4], r[7] ^ v, v, r[7], r[7:0] == 0 && (!c || sr[1]) && (op != 3 || sr[1]), r[8]};
		n = 1;
		while (o_done !== 1'b1 && n < 5) begin
			@(negedge i_clock);
			n++;
		end
		chk(n, !t ? 1 : op > 8 ? 2 : 2 + i_next_two_word);
		chk(o_pc_load, t);
		if (t) chk(o_pc_next, ep);
		chk(o_flags_upd, op inside {2, 3, 4});
		chk(o_status, sr);
	endtask
	// enable low: start and status write are ignored, all state holds
	task freeze();
		@(posedge i_clock);
		i_enable <= 0;
		i_start <= 1;
		i_status_wr <= 1;
		i_status_wdata <= ~sr;
		i_op <= `CSBU_OP_CMP;
		repeat (4) @(posedge i_clock);
		i_enable <= 1;
		i_start <= 0;
		i_status_wr <= 0;
		@(negedge i_clock);
		chk({o_status, o_pc_load, o_busy, o_done, o_flags_upd}, {sr, 4'h0});
	endtask
	// reset, sweep of every operation, chained compare
	initial begin
		void'($urandom(32'h1251DD45));
		repeat (12) @(posedge i_clock);
		i_nrst <= 1;
		@(negedge i_clock);
		chk({o_status, o_pc_load, o_busy, o_done, o_flags_upd}, 0);
		for (int k = 0; k < 300; k++) run(k % 24, $urandom % 4 == 0, $urandom % 2);
		freeze();
		run(`CSBU_OP_CMP, 1, 0);
		run(`CSBU_OP_CMP_C, 1, 0);
		print_verdict();
	end
endmodule
